// [hdl/frt_pkg.sv]
// constants for the free-run timer with input capture
package frt_pkg;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_COUNT    = 4'h1;
  localparam logic [3:0]  ADDR_CAPCFG   = 4'h2;
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;
  localparam logic [3:0]  ADDR_CLEAR    = 4'h4;
  localparam logic [3:0]  ADDR_ENABLE   = 4'h5;
  localparam logic [3:0]  ADDR_CAP0     = 4'h8;
  localparam int          NUM_CH        = 4;
  localparam int          CTRL_DIV_LSB  = 0;
  localparam int          CTRL_STOP_BIT = 2;
  localparam int          CTRL_CLR_BIT  = 3;
  localparam int          CTRL_IVS_BIT  = 4;
  localparam int          ST_OVF_BIT    = 4;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [4:0]  IRQ_OVF_NUM   = 5'h13;
  localparam logic [1:0]  EDGE_NONE     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  localparam logic [6:0]  PRE_MASK0     = 7'h00;
  localparam logic [6:0]  PRE_MASK1     = 7'h03;
  localparam logic [6:0]  PRE_MASK2     = 7'h0F;
  localparam logic [6:0]  PRE_MASK3     = 7'h3F;
endpackage : frt_pkg

// [hdl/frt_capture_ch.sv]
// one input capture channel: edge detect and data latch
`timescale 1ns/1ps
module frt_capture_ch
  import frt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        pin_in,
  input  wire logic [1:0]  edge_sel,
  input  wire logic [15:0] time_base,
  output logic             cap_pulse,
  output logic [15:0]      cap_value
);
  logic pin_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_in;
    end
  end

  always_comb begin
    case (edge_sel)
      EDGE_RISE: cap_pulse = pin_in & ~pin_q;
      EDGE_FALL: cap_pulse = ~pin_in & pin_q;
      EDGE_BOTH: cap_pulse = pin_in ^ pin_q;
      default:   cap_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cap_value <= COUNT_RESET;
    end else if (cap_pulse) begin
      cap_value <= time_base;
    end
  end

  a_cap_latch: assert property (@(posedge mclk) disable iff (reset)
    cap_pulse |=> cap_value == $past(time_base))
    else $error("capture did not latch time base");
endmodule : frt_capture_ch

// [hdl/frt_timer_top.sv]
// free-run timer with four capture channels behind avalon-mm
`timescale 1ns/1ps
module frt_timer_top
  import frt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  cap_pin,
  output logic             irq_q,
  output logic             xfer_req_q,
  output logic [4:0]       ovf_irq_num_q
);
  logic [15:0]       count_q;
  logic [6:0]        pre_q;
  logic [4:0]        ctrl_q;
  logic [7:0]        capcfg_q;
  logic [4:0]        status_q;
  logic [4:0]        enable_q;
  logic              ack_q;
  logic [NUM_CH-1:0] cap_pulse;
  logic [15:0]       cap_val [NUM_CH];
  logic              tick;
  logic              ovf;
  logic              wr_en;
  logic              rd_en;
  logic [4:0]        events;
  logic [31:0]       rdata_d;

  function automatic logic [6:0] pre_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_mask = PRE_MASK0;
      2'h1:    pre_mask = PRE_MASK1;
      2'h2:    pre_mask = PRE_MASK2;
      default: pre_mask = PRE_MASK3;
    endcase
  endfunction : pre_mask

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // one wait cycle per access; answer on the following edge
  assign avs_waitrequest = ~ack_q;
  assign wr_en = avs_write & ack_q;
  assign rd_en = avs_read & ack_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // prescaler divides by 1, 4, 16 or 64
  assign tick = ~ctrl_q[CTRL_STOP_BIT] &&
                ((pre_q & pre_mask(ctrl_q[1:0])) == pre_mask(ctrl_q[1:0]));
  assign ovf = tick && (count_q == 16'hFFFF);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_q <= 7'h00;
    end else if (ctrl_q[CTRL_STOP_BIT] || tick) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // control: divider, halt, irq-to-transfer steering
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q   <= 5'h00;
      capcfg_q <= 8'h00;
      enable_q <= 5'h00;
    end else if (wr_en) begin
      if (hit(avs_address, ADDR_CTRL)) begin
        ctrl_q <= {avs_writedata[CTRL_IVS_BIT], 1'b0,
                   avs_writedata[CTRL_STOP_BIT:0]};
      end
      if (hit(avs_address, ADDR_CAPCFG)) begin
        capcfg_q <= avs_writedata[7:0];
      end
      if (hit(avs_address, ADDR_ENABLE)) begin
        enable_q <= avs_writedata[4:0];
      end
    end
  end

  // reset and clear bit zero the counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_q <= COUNT_RESET;
    end else if (wr_en && hit(avs_address, ADDR_CTRL) &&
                 avs_writedata[CTRL_CLR_BIT]) begin
      count_q <= COUNT_RESET;
    end else if (wr_en && hit(avs_address, ADDR_COUNT) &&
                 ctrl_q[CTRL_STOP_BIT]) begin
      count_q <= avs_writedata[15:0];
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // four channels share the time base
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_cap
      frt_capture_ch u_ch (
        .mclk      (mclk),
        .reset     (reset),
        .pin_in    (cap_pin[g]),
        .edge_sel  (capcfg_q[2*g +: 2]),
        .time_base (count_q),
        .cap_pulse (cap_pulse[g]),
        .cap_value (cap_val[g])
      );
    end
  endgenerate

  // sticky flags, set wins over clear
  assign events = {ovf, cap_pulse};

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_q <= 5'h00;
    end else if (wr_en && hit(avs_address, ADDR_CLEAR)) begin
      status_q <= (status_q & ~avs_writedata[4:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // cpu interrupt; transfer service when steered
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_q         <= 1'b0;
      xfer_req_q    <= 1'b0;
      ovf_irq_num_q <= 5'h00;
    end else begin
      irq_q         <= ~ctrl_q[CTRL_IVS_BIT] & |(status_q & enable_q);
      xfer_req_q    <= ctrl_q[CTRL_IVS_BIT] & |(status_q & enable_q);
      ovf_irq_num_q <= IRQ_OVF_NUM;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      ADDR_CTRL:   rdata_d = {27'h0, ctrl_q};
      ADDR_COUNT:  rdata_d = {16'h0, count_q};
      ADDR_CAPCFG: rdata_d = {24'h0, capcfg_q};
      ADDR_STATUS: rdata_d = {27'h0, status_q};
      ADDR_ENABLE: rdata_d = {27'h0, enable_q};
      4'h8:        rdata_d = {16'h0, cap_val[0]};
      4'h9:        rdata_d = {16'h0, cap_val[1]};
      4'hA:        rdata_d = {16'h0, cap_val[2]};
      4'hB:        rdata_d = {16'h0, cap_val[3]};
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  // read data is captured in the wait cycle so it stands at the ack edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdata_d;
    end
  end

  a_count_wrap: assert property (@(posedge mclk) disable iff (reset)
    (ovf && !wr_en) |=> count_q == 16'h0000)
    else $error("counter did not wrap");

  a_ovf_flag: assert property (@(posedge mclk) disable iff (reset)
    ovf |=> status_q[ST_OVF_BIT])
    else $error("overflow flag not set");

  a_halt_hold: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_q[CTRL_STOP_BIT] && !wr_en) |=> $stable(count_q))
    else $error("halted counter moved");

  a_clear_cnt: assert property (@(posedge mclk) disable iff (reset)
    (wr_en && avs_address == ADDR_CTRL && avs_writedata[CTRL_CLR_BIT])
    |=> count_q == 16'h0000)
    else $error("clear bit ignored");

  // divide by 64 makes no further step in the 8 cycles after a step
  a_pre_div: assert property (@(posedge mclk) disable iff (reset)
    (tick && ctrl_q == 5'h03 && !wr_en) |-> ##1 !tick [*8])
    else $error("prescaler too fast");

  a_flag_stick: assert property (@(posedge mclk) disable iff (reset)
    (status_q[0] && !(wr_en && avs_address == ADDR_CLEAR))
    |=> status_q[0])
    else $error("capture flag dropped");

  // enabled capture raises irq two edges later
  a_cap_irq: assert property (@(posedge mclk) disable iff (reset)
    (cap_pulse[0] && enable_q[0] && !ctrl_q[CTRL_IVS_BIT] && !wr_en)
    |-> ##2 irq_q)
    else $error("capture irq missing");

  // steered requests never reach the cpu line
  a_xfer_steer: assert property (@(posedge mclk) disable iff (reset)
    $past(ctrl_q[CTRL_IVS_BIT]) |-> !irq_q)
    else $error("irq while steered to transfer");

  a_irq_num: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> ovf_irq_num_q == 5'h13)
    else $error("wrong request number");
endmodule : frt_timer_top

// [sim/frt_pin_src.sv]
// model of the sources that drive the four capture pins
`timescale 1ns/1ps
module frt_pin_src (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic [3:0] want,
  output logic [3:0]      cap_pin
);
  logic [3:0] mid_q;
  // slow sources lag one more cycle, pins stay mclk-synchronous
  always_ff @(posedge mclk) begin
    mid_q   <= want;
    cap_pin <= slow ? mid_q : want;
  end
endmodule : frt_pin_src

// [sim/frt_timer_top_tb.sv]
// self-checking bench for the free-run timer with capture
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module frt_timer_top_tb;
  import frt_pkg::*;
  typedef struct {int ch; logic [1:0] md; logic l0, l1, hit;} frt_row_s;
  logic        mclk = 0, reset = 1, avs_read = 0, avs_write = 0, slow = 0;
  logic [3:0]  avs_address = 0, want = 0, cap_pin;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic        avs_waitrequest, irq_q, xfer_req_q;
  logic [4:0]  ovf_irq_num_q;
  int          fails = 0, n_checks = 0, i, r;
  // every edge mode; rise and fall each with a matching and a non-matching edge, both with two matching edges, none with one
  frt_row_s rows [7] = '{'{0, EDGE_RISE, 0, 1, 1}, '{1, EDGE_FALL, 0, 1, 0},
    '{2, EDGE_FALL, 1, 0, 1}, '{3, EDGE_BOTH, 0, 1, 1},
    '{3, EDGE_BOTH, 1, 0, 1}, '{0, EDGE_RISE, 1, 0, 0},
    '{1, EDGE_NONE, 0, 1, 0}};
  always #5 mclk = ~mclk;
  frt_timer_top frt_timer_top_inst (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cap_pin(cap_pin), .irq_q(irq_q), .xfer_req_q(xfer_req_q),
    .ovf_irq_num_q(ovf_irq_num_q));
  frt_pin_src frt_pin_src_inst (.mclk(mclk), .slow(slow), .want(want),
    .cap_pin(cap_pin));
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // entered just after an edge; leaves one edge after release
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    // waitrequest is looked at mid-cycle, where it has settled
    for (k = 0; k < 20; k++) begin
      @(negedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    @(posedge mclk);
    rd = avs_readdata;
    avs_read  <= 0;
    avs_write <= 0;
    if (k == 20) begin fails++; results(); end
    @(posedge mclk);
  endtask : bus
  initial begin
    repeat (5) @(posedge mclk);
    `CHK("wait_rst", 1'b1, avs_waitrequest)
    `CHK("irq_rst", 1'b0, irq_q)
    reset <= 0;
    repeat (2) @(posedge mclk);
    `CHK("irq_num", IRQ_OVF_NUM, ovf_irq_num_q)
    bus(0, ADDR_COUNT, 0);
    `CHK("count_rst", 1'b1, rd < 4)
    bus(0, ADDR_STATUS, 0);
    `CHK("status_rst", 32'h0, rd)
    $display("test reset done");
    // halted counter makes the captured value known
    bus(1, ADDR_CTRL, 32'h4);
    foreach (rows[j]) begin
      slow <= (j % 2 == 1);
      bus(1, ADDR_CAPCFG, 32'(rows[j].md) << (2 * rows[j].ch));
      want <= {4{rows[j].l0}};
      repeat (4) @(posedge mclk);
      bus(1, ADDR_COUNT, 32'h1000 + j * 32'h111);
      bus(0, ADDR_COUNT, 0);
      `CHK("load", 32'h1000 + j * 32'h111, rd)
      bus(1, ADDR_CLEAR, 32'h1F);
      want[rows[j].ch] <= rows[j].l1;
      repeat (4) @(posedge mclk);
      bus(0, ADDR_STATUS, 0);
      `CHK("cap_flag", 32'(rows[j].hit) << rows[j].ch, rd)
      bus(0, ADDR_CAP0 + 4'(rows[j].ch), 0);
      if (rows[j].hit) `CHK("cap_val", 32'h1000 + j * 32'h111, rd)
    end
    $display("test edges done");
    bus(1, ADDR_CAPCFG, 32'h1);
    want <= 0;
    repeat (4) @(posedge mclk);
    bus(1, ADDR_CLEAR, 32'h1F);
    bus(1, ADDR_ENABLE, 32'h1);
    want[0] <= 1;
    repeat (4) @(posedge mclk);
    `CHK("cap_irq", 1'b1, irq_q)
    bus(1, ADDR_ENABLE, 0);
    repeat (2) @(posedge mclk);
    `CHK("masked", 1'b0, irq_q)
    bus(1, ADDR_ENABLE, 32'h1);
    bus(1, ADDR_CTRL, 32'h14);
    repeat (2) @(posedge mclk);
    `CHK("cap_xfer", 2'b10, {xfer_req_q, irq_q})
    bus(1, ADDR_CLEAR, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK("cleared", 1'b0, xfer_req_q)
    $display("test capture irq done");
    bus(1, ADDR_COUNT, 32'hFFFA);
    bus(1, ADDR_ENABLE, 32'h10);
    bus(1, ADDR_CTRL, 32'h0);
    repeat (10) @(posedge mclk);
    bus(0, ADDR_STATUS, 0);
    `CHK("ovf_flag", 32'h10, rd)
    `CHK("ovf_irq", 1'b1, irq_q)
    bus(0, ADDR_COUNT, 0);
    `CHK("wrap", 1'b1, rd < 32'h20)
    bus(1, ADDR_CTRL, 32'h10);
    repeat (2) @(posedge mclk);
    `CHK("ovf_xfer", 2'b10, {xfer_req_q, irq_q})
    bus(1, ADDR_CLEAR, 32'h10);
    // running counter: clear bit works, a load is refused
    bus(1, ADDR_CTRL, 32'h8);
    bus(0, ADDR_COUNT, 0);
    `CHK("sw_clear", 1'b1, rd < 8)
    bus(1, ADDR_COUNT, 32'hABCD);
    bus(0, ADDR_COUNT, 0);
    `CHK("run_load", 1'b1, rd < 16)
    bus(1, 4'hF, 32'hFFFF);
    bus(0, 4'hF, 0);
    `CHK("unmapped", 32'h0, rd)
    $display("test overflow done");
    // 259 edges between the run and halt writes
    for (i = 0; i < 4; i++) begin
      bus(1, ADDR_CTRL, 32'h4 | i);
      bus(1, ADDR_COUNT, 0);
      bus(1, ADDR_CTRL, i);
      repeat (256) @(posedge mclk);
      bus(1, ADDR_CTRL, 32'h4 | i);
      bus(0, ADDR_COUNT, 0);
      r = 259 >> (2 * i);
      `CHK("divide", 1'b1, rd + 2 >= r && rd <= r + 2)
    end
    $display("test prescaler done");
    results();
  end
endmodule : frt_timer_top_tb
